// ---- phy_ctl_pkg.sv ----
/*
 * Constants, types and register map for the transceiver control block.
 * Assumes a 125 MHz system clock; all timing counts derive from it.
 */
package phy_ctl_pkg;

   // -----------------------------------------------------------------
   // Register map (index addressing on the plain register port)
   // -----------------------------------------------------------------
   localparam int             ADDR_W             = 5;
   localparam int             DATA_W             = 16;
   localparam logic [4:0]     BCR_IDX            = 5'h00;
   localparam logic [4:0]     BSR_IDX            = 5'h01;
   localparam logic [4:0]     ADV_IDX            = 5'h04;

   localparam int             BCR_RST_BIT        = 15;
   localparam int             BCR_AN_EN_BIT      = 12;
   localparam int             BCR_PD_BIT         = 11;
   localparam int             BCR_AN_RESTART_BIT = 9;
   localparam int             BSR_PRE_SUP_BIT    = 6;
   localparam int             BSR_AN_DONE_BIT    = 5;
   localparam int             BSR_RF_BIT         = 4;
   localparam int             BSR_LINK_BIT       = 2;
   localparam int             ADV_RF_BIT         = 13;

   localparam logic           AN_EN_RST          = 1'b1;
   localparam logic [15:0]    ADV_RST            = 16'h01e1;
   localparam logic [15:0]    BSR_FIXED          = 16'h7808;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int             CLK_MHZ            = 125;
   localparam int             PULSE_W_NS         = 100;
   localparam int             NLP_PER_US         = 16000;
   localparam int             FLP_CLK_NS         = 125000;
   localparam int             FLP_DATA_NS        = 62500;
   localparam int             FLP_BURST_US       = 16000;
   localparam int             TRX_BLINK_HZ       = 10;
   localparam int             COL_BLINK_HZ       = 20;
   localparam int             FLP_LAST_BIT       = 16;

   localparam int             PULSE_W_CYC        = PULSE_W_NS * CLK_MHZ / 1000;
   localparam int             NLP_PER_CYC        = NLP_PER_US * CLK_MHZ;
   localparam int             FLP_CLK_CYC        = FLP_CLK_NS * CLK_MHZ / 1000;
   localparam int             FLP_DATA_CYC       = FLP_DATA_NS * CLK_MHZ / 1000;
   localparam int             FLP_BURST_CYC      = FLP_BURST_US * CLK_MHZ;
   localparam int             TRX_HALF_CYC       = CLK_MHZ * 1000000 / (2 * TRX_BLINK_HZ);
   localparam int             COL_HALF_CYC       = CLK_MHZ * 1000000 / (2 * COL_BLINK_HZ);

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_s;

   typedef struct packed {
      logic link_up;
      logic speed_100;
      logic rx_act;
      logic tx_act;
      logic col;
      logic an_done;
      logic partner_rf;
      logic local_fault;
   } line_status_s;

   typedef struct packed {
      logic speed;
      logic rx;
      logic tx;
      logic link;
      logic col;
   } led_s;

   typedef enum logic [4:0] {
      LP_WAIT = 5'b00001,
      LP_CLK  = 5'b00010,
      LP_HALF = 5'b00100,
      LP_DATA = 5'b01000,
      LP_REST = 5'b10000
   } lp_state_e;

endpackage

// ---- phy_ctl.sv ----
/*
 * Transceiver control: power-down, hardware and software reset with
 * strap capture, five LEDs, management register file and link pulse
 * generation (normal and fast link pulses).
 * Assumes line status inputs come from logic on clk_sys; the reset pin
 * and LED pins are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps

// How it works
// - Power-down bit 11 of control register set puts device in power-down.
// - In power-down, transmit line and all LEDs float; MII is isolated.
// - Register port keeps working during power-down.
// - Power-down ends on bit 11 clear, hardware reset or software reset.
// - Speed LED on at 100 Mb/s, off at 10 Mb/s.
// - Receive and transmit LEDs blink at 10 Hz when active without collision.
// - Link LED on whenever a valid link exists.
// - Collision LED blinks at 20 Hz during collision.
// - Writing bit 15 resets all but the strap address, self-clears, raises reset-done output.
// - Both resets restore defaults; only hardware reset recaptures strap-derived ones.
// - Straps sampled on LED pins during hardware reset; pins drive afterwards.
// - Management address comes from LED pin straps.
// - Status register bit 6 reads one for preamble suppression.
// - Accesses are answered with no preamble check, the first one included.
// - Remote fault travels in bit 13 of the link code word.
// - Local fault sets advertised remote fault bit and restarts negotiation.
// - Advertised remote fault stays set until negotiation succeeds or a write leaves bit 13 zero, then clears.
// - Partner remote fault sets remote fault status bit.
// - Normal link pulses 100 ns wide, period within 8 to 24 ms.
// - Fast pulse clocks 125 us apart, data pulse 62.5 us after clock.
// - Burst holds 17 to 33 pulses, repeating every 16 ms.
module phy_ctl #(
   parameter int NLP_PER_P   = phy_ctl_pkg::NLP_PER_CYC,
   parameter int FLP_CLK_P   = phy_ctl_pkg::FLP_CLK_CYC,
   parameter int FLP_DATA_P  = phy_ctl_pkg::FLP_DATA_CYC,
   parameter int FLP_BURST_P = phy_ctl_pkg::FLP_BURST_CYC,
   parameter int TRX_HALF_P  = phy_ctl_pkg::TRX_HALF_CYC,
   parameter int COL_HALF_P  = phy_ctl_pkg::COL_HALF_CYC
) (
   input  wire logic                      clk_sys,
   input  wire logic                      srst,
   input  wire logic                      hw_rst_pin_n,
   input  wire phy_ctl_pkg::reg_req_s     reg_req,
   output      logic [15:0]               reg_rdata_q,
   input  wire phy_ctl_pkg::line_status_s line_st,
   input  wire logic [4:0]                led_in,
   output      phy_ctl_pkg::led_s         led_out_q,
   output      logic [4:0]                led_oe_n_q,
   output      logic                      tx_pulse_q,
   output      logic                      tx_oe_n_q,
   output      logic                      mii_isolate_q,
   output      logic                      reset_done_q,
   output      logic [4:0]                phy_addr_q,
   output      logic                      an_restart_q
);
   import phy_ctl_pkg::*;

   // -----------------------------------------------------------------
   // Synchronisers and reset
   // -----------------------------------------------------------------
   logic       pin_s1_q;
   logic       pin_s2_q;
   logic [4:0] led_s1_q;
   logic [4:0] led_s2_q;
   logic       hw_rst;
   logic       sw_rst_q;
   logic       all_rst;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= hw_rst_pin_n;
         pin_s2_q <= pin_s1_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      led_s1_q <= led_in;
      led_s2_q <= led_s1_q;
   end

   // Pin is held low long enough by the board; no stretching here
   assign hw_rst  = srst | ~pin_s2_q;
   assign all_rst = hw_rst | sw_rst_q;

   // -----------------------------------------------------------------
   // Register port decode
   // -----------------------------------------------------------------
   logic bcr_wr;
   logic adv_wr;
   logic bsr_rd;

   // No preamble or power state gates the decode
   assign bcr_wr = reg_req.wr && (reg_req.addr == BCR_IDX);
   assign adv_wr = reg_req.wr && (reg_req.addr == ADV_IDX);
   assign bsr_rd = reg_req.rd && (reg_req.addr == BSR_IDX);

   always_ff @(posedge clk_sys) begin
      if (hw_rst)
         sw_rst_q <= 1'b0;
      else
         sw_rst_q <= bcr_wr && reg_req.wdata[BCR_RST_BIT];
   end

   // Reset bit self-clears: it only lives as the one-cycle sw_rst_q
   always_ff @(posedge clk_sys) begin
      if (hw_rst)
         reset_done_q <= 1'b0;
      else if (sw_rst_q)
         reset_done_q <= 1'b1;
   end

   // Straps read while the LED drivers are off during reset
   always_ff @(posedge clk_sys) begin
      if (hw_rst)
         phy_addr_q <= led_s2_q;
   end

   // -----------------------------------------------------------------
   // Control register
   // -----------------------------------------------------------------
   logic pd_q;
   logic an_en_q;

   always_ff @(posedge clk_sys) begin
      if (all_rst)
         pd_q <= 1'b0;
      else if (bcr_wr && !reg_req.wdata[BCR_RST_BIT])
         pd_q <= reg_req.wdata[BCR_PD_BIT];
   end

   always_ff @(posedge clk_sys) begin
      if (all_rst)
         an_en_q <= AN_EN_RST;
      else if (bcr_wr)
         an_en_q <= reg_req.wdata[BCR_AN_EN_BIT];
   end

   // -----------------------------------------------------------------
   // Remote fault
   // -----------------------------------------------------------------
   logic        an_done_q;
   logic        an_ok;
   logic        adv_rf_q;
   logic [15:0] adv_q;
   logic        rf_status_q;
   logic [15:0] lcw;

   always_ff @(posedge clk_sys) begin
      if (all_rst)
         an_done_q <= 1'b0;
      else
         an_done_q <= line_st.an_done;
   end

   assign an_ok = line_st.an_done & ~an_done_q;

   always_ff @(posedge clk_sys) begin
      if (all_rst)
         adv_q <= ADV_RST;
      else if (adv_wr)
         adv_q <= reg_req.wdata;
   end

   // Set wins over the clearing negotiation success
   always_ff @(posedge clk_sys) begin
      if (all_rst)
         adv_rf_q <= 1'b0;
      else if (line_st.local_fault || (adv_wr && reg_req.wdata[ADV_RF_BIT]))
         adv_rf_q <= 1'b1;
      else if (an_ok || adv_wr)
         adv_rf_q <= 1'b0;
   end

   always_ff @(posedge clk_sys) begin
      if (all_rst)
         an_restart_q <= 1'b0;
      else
         an_restart_q <= line_st.local_fault
                         || (bcr_wr && reg_req.wdata[BCR_AN_RESTART_BIT]);
   end

   // Sticky until status is read; a new fault in the read cycle is kept
   always_ff @(posedge clk_sys) begin
      if (all_rst)
         rf_status_q <= 1'b0;
      else if (line_st.partner_rf)
         rf_status_q <= 1'b1;
      else if (bsr_rd)
         rf_status_q <= 1'b0;
   end

   always_comb begin
      lcw             = adv_q;
      lcw[ADV_RF_BIT] = adv_rf_q;
   end

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   logic [15:0] rd_val;

   always_comb begin
      rd_val = 16'h0000;
      if (reg_req.addr == BCR_IDX) begin
         rd_val[BCR_AN_EN_BIT] = an_en_q;
         rd_val[BCR_PD_BIT]    = pd_q;
      end else if (reg_req.addr == BSR_IDX) begin
         rd_val                  = BSR_FIXED;
         rd_val[BSR_PRE_SUP_BIT] = 1'b1;
         rd_val[BSR_AN_DONE_BIT] = line_st.an_done;
         rd_val[BSR_RF_BIT]      = rf_status_q;
         rd_val[BSR_LINK_BIT]    = line_st.link_up;
      end else if (reg_req.addr == ADV_IDX) begin
         rd_val = lcw;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (hw_rst)
         reg_rdata_q <= 16'h0000;
      else
         reg_rdata_q <= reg_req.rd ? rd_val : 16'h0000;
   end

   // -----------------------------------------------------------------
   // LEDs
   // -----------------------------------------------------------------
   logic [2:0] blink_en;
   logic [2:0] blink_ph_q;

   // Index 0 receive, 1 transmit, 2 collision
   assign blink_en[0] = line_st.rx_act & ~line_st.col;
   assign blink_en[1] = line_st.tx_act & ~line_st.col;
   assign blink_en[2] = line_st.col;

   for (genvar i = 0; i < 3; i++) begin : g_blink
      localparam int HALF = (i == 2) ? COL_HALF_P : TRX_HALF_P;
      logic [31:0] cnt_q;
      // Phase restarts off, so activity shorter than one half period never lights
      always_ff @(posedge clk_sys) begin
         if (all_rst || !blink_en[i]) begin
            cnt_q         <= 32'h0000_0000;
            blink_ph_q[i] <= 1'b0;
         end else if (cnt_q == 32'(HALF - 1)) begin
            cnt_q         <= 32'h0000_0000;
            blink_ph_q[i] <= ~blink_ph_q[i];
         end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (all_rst) begin
         led_out_q <= '0;
      end else begin
         led_out_q.speed <= line_st.speed_100;
         led_out_q.link  <= line_st.link_up;
         led_out_q.rx    <= blink_ph_q[0];
         led_out_q.tx    <= blink_ph_q[1];
         led_out_q.col   <= blink_ph_q[2];
      end
   end

   // Released during hardware reset so straps can be read
   always_ff @(posedge clk_sys) begin
      if (hw_rst)
         led_oe_n_q <= 5'h1f;
      else
         led_oe_n_q <= {5{pd_q}};
   end

   always_ff @(posedge clk_sys) begin
      if (hw_rst) begin
         tx_oe_n_q     <= 1'b1;
         mii_isolate_q <= 1'b0;
      end else begin
         tx_oe_n_q     <= pd_q;
         mii_isolate_q <= pd_q;
      end
   end

   // -----------------------------------------------------------------
   // Link pulse generator
   // -----------------------------------------------------------------
   lp_state_e   lp_q;
   logic [31:0] tmr_q;
   logic [31:0] per_q;
   logic [4:0]  bit_q;
   logic        flp_mode;
   logic        pulses_on;
   logic [31:0] per_lim;
   logic        tx_pulse_d;

   assign flp_mode  = an_en_q & ~line_st.an_done;
   assign pulses_on = flp_mode | ~line_st.speed_100;
   assign per_lim   = flp_mode ? 32'(FLP_BURST_P) : 32'(NLP_PER_P);

   always_ff @(posedge clk_sys) begin
      if (all_rst || pd_q) begin
         lp_q  <= LP_WAIT;
         tmr_q <= 32'h0000_0000;
         per_q <= 32'h0000_0000;
         bit_q <= 5'h00;
      end else begin
         per_q <= per_q + 32'h0000_0001;
         tmr_q <= tmr_q + 32'h0000_0001;
         case (lp_q)
            LP_WAIT: begin
               // Restart skips the rest of the period
               if ((an_restart_q && flp_mode)
                   || (pulses_on && per_q >= per_lim - 32'h0000_0001)) begin
                  lp_q  <= LP_CLK;
                  tmr_q <= 32'h0000_0000;
                  per_q <= 32'h0000_0000;
                  bit_q <= 5'h00;
               end
            end
            LP_CLK: begin
               if (tmr_q == 32'(PULSE_W_CYC - 1)) begin
                  if (!flp_mode || bit_q == 5'(FLP_LAST_BIT))
                     lp_q <= LP_WAIT;
                  else
                     lp_q <= LP_HALF;
               end
            end
            LP_HALF: begin
               if (tmr_q == 32'(FLP_DATA_P - 1))
                  lp_q <= LP_DATA;
            end
            LP_DATA: begin
               if (tmr_q == 32'(FLP_DATA_P + PULSE_W_CYC - 1))
                  lp_q <= LP_REST;
            end
            LP_REST: begin
               if (tmr_q == 32'(FLP_CLK_P - 1)) begin
                  lp_q  <= LP_CLK;
                  tmr_q <= 32'h0000_0000;
                  bit_q <= bit_q + 5'h01;
               end
            end
            default: lp_q <= LP_WAIT;
         endcase
      end
   end

   // Code word goes out low bit first; only one bits get a data pulse
   assign tx_pulse_d = (lp_q == LP_CLK) || ((lp_q == LP_DATA) && lcw[bit_q[3:0]]);

   always_ff @(posedge clk_sys) begin
      if (all_rst || pd_q)
         tx_pulse_q <= 1'b0;
      else
         tx_pulse_q <= tx_pulse_d;
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   logic [7:0] plen_q;

   always_ff @(posedge clk_sys) begin
      if (srst || !tx_pulse_q)
         plen_q <= 8'h00;
      else
         plen_q <= plen_q + 8'h01;
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   sequence pd_write_s;
      bcr_wr && reg_req.wdata[BCR_PD_BIT] && !reg_req.wdata[BCR_RST_BIT] && !hw_rst;
   endsequence

   sequence sw_write_s;
      bcr_wr && reg_req.wdata[BCR_RST_BIT] && !hw_rst;
   endsequence

   AST_PD_ENTER: assert property (pd_write_s ##1 !all_rst |=>
      (led_oe_n_q == 5'h1f) && tx_oe_n_q && mii_isolate_q)
      else $error("power-down did not float outputs");
   AST_PD_REGS: assert property (pd_q && reg_req.rd && reg_req.addr == BSR_IDX
      && !hw_rst |=> reg_rdata_q[BSR_PRE_SUP_BIT])
      else $error("register read failed in power-down");
   AST_SW_RST: assert property (sw_write_s |=> sw_rst_q ##1 (!pd_q && reset_done_q
      && an_en_q == AN_EN_RST))
      else $error("software reset sequence wrong");
   AST_PD_EXIT: assert property (sw_rst_q |=> !pd_q)
      else $error("power-down survived reset");
   AST_STRAP: assert property (hw_rst |=> phy_addr_q == $past(led_s2_q))
      else $error("strap address not captured");
   AST_SPEED: assert property (!all_rst |=>
      led_out_q.speed == $past(line_st.speed_100))
      else $error("speed LED mismatch");
   AST_NO_COL_RX: assert property (line_st.col ##1 !all_rst |=>
      !led_out_q.rx && !led_out_q.tx)
      else $error("activity LED lit during collision");
   AST_RF_HOLD: assert property (adv_rf_q && !an_ok && !adv_wr && !all_rst
      |=> adv_rf_q)
      else $error("remote fault dropped early");
   AST_RF_STATUS: assert property (line_st.partner_rf && !all_rst |=> rf_status_q)
      else $error("partner fault not recorded");
   AST_PULSE_W: assert property ($fell(tx_pulse_q) && !$past(all_rst) && !$past(pd_q)
      |-> $past(plen_q) == 8'(PULSE_W_CYC - 1))
      else $error("link pulse width wrong");

endmodule

// ---- led_pin_model.sv ----
/*
 * Model of the board around the LED/strap pins.
 * Assumes a weak strap resistor on every pin; the device drives when oe_n is low.
 */
`timescale 1ns/10ps
module led_pin_model (
   input  wire phy_ctl_pkg::led_s led_out_q,
   input  wire logic [4:0]        led_oe_n_q,
   input  wire logic [4:0]        strap,
   output      logic [4:0]        led_in
);
   import phy_ctl_pkg::*;
   // ---------------------------------------------
   // Pin level
   // ---------------------------------------------
   // Released pin falls back to its resistor
   assign led_in = (led_oe_n_q & strap) | (~led_oe_n_q & led_out_q);
endmodule

// ---- test_phy_power_reset_led_control.sv ----
/*
 * Self-checking bench for the transceiver control block.
 * Assumes shortened timing parameters; all expectations derive from them.
 */
`timescale 1ns/10ps
module test_phy_power_reset_led_control;
   import phy_ctl_pkg::*;
   localparam int NLP_P   = 100;
   localparam int BURST_P = 1000;
   typedef struct packed {
      logic [4:0]  a;
      logic [15:0] e;
   } row_s;
   logic         clk_sys, srst, hw_rst_pin_n;
   reg_req_s     req;
   line_status_s ls;
   led_s         led_out_q;
   logic [4:0]   strap, led_in, led_oe_n_q, phy_addr_q;
   logic [15:0]  reg_rdata_q;
   logic         tx_pulse_q, tx_oe_n_q, mii_isolate_q, reset_done_q, an_restart_q;
   int           num_errors, total_checks, cyc, rises, last_rise, gap, width, wcnt;
   int           tog [5];
   row_s         rows [4];

   phy_ctl #(.NLP_PER_P(NLP_P), .FLP_CLK_P(40), .FLP_DATA_P(20), .FLP_BURST_P(BURST_P),
      .TRX_HALF_P(10), .COL_HALF_P(5)) uut (.clk_sys(clk_sys), .srst(srst),
      .hw_rst_pin_n(hw_rst_pin_n), .reg_req(req), .reg_rdata_q(reg_rdata_q),
      .line_st(ls), .led_in(led_in), .led_out_q(led_out_q), .led_oe_n_q(led_oe_n_q),
      .tx_pulse_q(tx_pulse_q), .tx_oe_n_q(tx_oe_n_q), .mii_isolate_q(mii_isolate_q),
      .reset_done_q(reset_done_q), .phy_addr_q(phy_addr_q), .an_restart_q(an_restart_q));
   led_pin_model pins (.led_out_q(led_out_q), .led_oe_n_q(led_oe_n_q), .strap(strap),
      .led_in(led_in));

   // ---------------------------------------------
   // Clock, timeout, helpers
   // ---------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task give_verdict;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Whole run needs about 3700 cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         give_verdict;
      end
   end

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      req.wr <= 1'b0; // Idle cycle before any next access
   endtask

   // Read data stands only in the cycle after the strobe
   task rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      req.rd <= 1'b0;
      #1 chk(reg_rdata_q, e);
   endtask

   // Counts LED toggles, pulse rises, pulse width and spacing
   task watch(input int n);
      led_s p;
      logic t;
      tog = '{default: 0};
      rises = 0;
      repeat (n) begin
         p = led_out_q;
         t = tx_pulse_q;
         @(posedge clk_sys);
         #1;
         for (int k = 0; k < 5; k++) begin
            if (led_out_q[k] !== p[k]) tog[k]++;
         end
         if (tx_pulse_q === 1'b1) wcnt++;
         if (tx_pulse_q === 1'b1 && t === 1'b0) begin
            rises++;
            gap = cyc - last_rise;
            last_rise = cyc;
         end
         if (tx_pulse_q === 1'b0 && t === 1'b1) begin
            width = wcnt;
            wcnt = 0;
         end
      end
   endtask

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      srst = 1'b1;
      hw_rst_pin_n = 1'b1;
      req = '0;
      ls = '0;
      strap = 5'h15;
      num_errors = 0;
      total_checks = 0;
      cyc = 0;
      wcnt = 0;
      last_rise = 0;
      rows[0] = '{BCR_IDX, 16'(AN_EN_RST) << BCR_AN_EN_BIT};
      rows[1] = '{BSR_IDX, BSR_FIXED | 16'h0040};
      rows[2] = '{ADV_IDX, ADV_RST};
      rows[3] = '{5'h02, 16'h0000};
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      tick(4); // First access only once reset has settled
      chk(16'(phy_addr_q), 16'h0015);
      foreach (rows[i]) rd(rows[i].a, rows[i].e);
      watch(BURST_P);
      watch(BURST_P);
      chk(16'(rises), 16'(17 + $countones(ADV_RST)));
      chk(16'(width), 16'(PULSE_W_CYC));
      @(posedge clk_sys);
      ls.an_done <= 1'b1;
      watch(3 * NLP_P);
      chk(16'(gap), 16'(NLP_P));
      @(posedge clk_sys);
      ls <= '{link_up: 1'b1, speed_100: 1'b1, rx_act: 1'b1, an_done: 1'b1, default: 1'b0};
      tick(2);
      chk(16'(led_out_q.speed), 16'h0001);
      chk(16'(led_out_q.link), 16'h0001);
      watch(100);
      chk(16'(tog[3] inside {[8:10]}), 16'h0001);
      chk(16'(tog[2]), 16'h0000);
      @(posedge clk_sys);
      ls.col <= 1'b1;
      ls.tx_act <= 1'b1;
      tick(2);
      watch(100);
      chk(16'(tog[3] + tog[2]), 16'h0000);
      chk(16'(tog[0] inside {[16:20]}), 16'h0001);
      @(posedge clk_sys);
      ls.col <= 1'b0;
      ls.speed_100 <= 1'b0;
      tick(2);
      chk(16'(led_out_q.speed), 16'h0000);
      watch(100);
      chk(16'(tog[2] inside {[8:10]}), 16'h0001);
      wr(BCR_IDX, 16'h1800);
      tick(2);
      chk(16'(led_oe_n_q), 16'h001f);
      chk(16'({tx_oe_n_q, mii_isolate_q}), 16'h0003);
      rd(BSR_IDX, BSR_FIXED | 16'h0064);
      wr(BCR_IDX, 16'h1000);
      tick(2);
      chk(16'({led_oe_n_q, mii_isolate_q}), 16'h0000);
      wr(ADV_IDX, 16'h0001);
      wr(BCR_IDX, 16'h1800);
      wr(BCR_IDX, 16'h8800);
      tick(3);
      chk(16'({reset_done_q, mii_isolate_q}), 16'h0002);
      rd(BCR_IDX, 16'h1000);
      rd(ADV_IDX, ADV_RST);
      @(posedge clk_sys);
      ls.an_done <= 1'b0;
      @(posedge clk_sys);
      ls.local_fault <= 1'b1;
      @(posedge clk_sys);
      ls.local_fault <= 1'b0;
      #1 chk(16'(an_restart_q), 16'h0001);
      rd(ADV_IDX, ADV_RST | 16'h2000);
      watch(BURST_P);
      chk(16'(rises), 16'(18 + $countones(ADV_RST)));
      rd(ADV_IDX, ADV_RST | 16'h2000);
      @(posedge clk_sys);
      ls.an_done <= 1'b1;
      ls.partner_rf <= 1'b1;
      tick(2);
      rd(ADV_IDX, ADV_RST);
      rd(BSR_IDX, BSR_FIXED | 16'h0074);
      wr(BCR_IDX, 16'h1800);
      strap <= 5'h0a;
      hw_rst_pin_n <= 1'b0;
      tick(5);
      chk(16'({led_oe_n_q, reset_done_q}), 16'h003e);
      @(posedge clk_sys);
      hw_rst_pin_n <= 1'b1;
      tick(4);
      chk(16'(phy_addr_q), 16'h000a);
      chk(16'({led_oe_n_q, mii_isolate_q}), 16'h0000);
      rd(BCR_IDX, 16'h1000);
      give_verdict;
   end
endmodule
